/* inc/adc_seq_pkg.sv */
// shared constants for the converter sequencer
package adc_seq_pkg;
	localparam logic [7:0] addr_control     = 8'h00;
	localparam logic [7:0] addr_clock_ctl   = 8'h01;
	localparam logic [7:0] addr_result_high = 8'h02;
	localparam logic [7:0] addr_result_low  = 8'h03;
	localparam logic [7:0] addr_status      = 8'h04;
	localparam int         bit_on           = 0;
	localparam int         bit_go           = 1;
	localparam int         chan_lsb         = 2;
	localparam int         chan_msb         = 6;
	localparam int         clksel_lsb       = 4;
	localparam int         clksel_msb       = 6;
	localparam int         bit_done         = 0;
	localparam int         bit_irq_en       = 1;
	localparam logic [7:0] control_reset    = 8'h00;
	localparam logic [7:0] clock_ctl_reset  = 8'h00;
	localparam logic [9:0] result_reset     = 10'h000;
	localparam logic [2:0] clk_div8         = 3'h1;
	localparam logic [2:0] clk_div16        = 3'h5;
	localparam logic [2:0] clk_div32        = 3'h2;
	localparam logic [2:0] clk_div64        = 3'h6;
	localparam logic [1:0] clk_rc_low       = 2'h3;
	localparam logic [6:0] div8_count       = 7'h08;
	localparam logic [6:0] div16_count      = 7'h10;
	localparam logic [6:0] div32_count      = 7'h20;
	localparam logic [6:0] div64_count      = 7'h40;
	localparam int         result_bits      = 10;
	localparam logic [3:0] conv_periods     = 4'hb;
	localparam logic [3:0] abort_periods    = 4'h2;
endpackage

/* verilog/adc_tick_gen.sv */
// conversion clock tick generator: one-cycle tick per bit period
`timescale 1ns/1ns
module adc_tick_gen (
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	input  wire logic       clk_en_in,
	input  wire logic       run_in,
	input  wire logic [2:0] clk_select_in,
	input  wire logic       rc_clk_in,
	output logic            tick_out
);
	logic [6:0] div_reg;
	logic [6:0] limit;
	logic       rc_s1_reg;
	logic       rc_s2_reg;
	logic       rc_s3_reg;
	logic       rc_level_reg;
	logic       rc_edge;
	logic       use_rc;

	assign use_rc = (clk_select_in[1:0] == adc_seq_pkg::clk_rc_low);

	// reserved codes fall back to the fastest divider
	always_comb begin
		case (clk_select_in)
			adc_seq_pkg::clk_div16: limit = adc_seq_pkg::div16_count;
			adc_seq_pkg::clk_div32: limit = adc_seq_pkg::div32_count;
			adc_seq_pkg::clk_div64: limit = adc_seq_pkg::div64_count;
			default:                limit = adc_seq_pkg::div8_count;
		endcase
	end

	// async rc clock: a level counts once stages two and three agree
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rc_s1_reg    <= 1'b0;
			rc_s2_reg    <= 1'b0;
			rc_s3_reg    <= 1'b0;
			rc_level_reg <= 1'b0;
		end else if (clk_en_in) begin
			rc_s1_reg <= rc_clk_in;
			rc_s2_reg <= rc_s1_reg;
			rc_s3_reg <= rc_s2_reg;
			if (rc_s2_reg == rc_s3_reg)
				rc_level_reg <= rc_s3_reg;
		end
	end
	assign rc_edge = (rc_s2_reg == rc_s3_reg) & rc_s3_reg & ~rc_level_reg;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			div_reg <= 7'h00;
		else if (clk_en_in) begin
			if (!run_in || div_reg >= limit - 7'h01)
				div_reg <= 7'h00;
			else
				div_reg <= div_reg + 7'h01;
		end
	end

	assign tick_out = clk_en_in & run_in &
		(use_rc ? rc_edge : (div_reg == limit - 7'h01));
endmodule

/* verilog/adc_conversion_sequencer.sv */
// converter sequencer: control registers, sar timing, abort and results
// Notes on behaviour
// [RULE1] converter runs only while converter_on set
// [RULE2] writing go flag one starts conversion
// [RULE3] hardware clears go flag at completion
// [RULE4] done flag set each completion, sticky
// [RULE5] completion loads result byte pair
// [RULE6] clearing go mid-conversion aborts it
// [RULE7] abort keeps previous completed result
// [RULE8] abort waits two conversion clock periods
// [RULE9] after wait, acquisition restarts automatically
// [RULE10] reset clears registers, stops conversion
// [RULE11] no conversion runs during sleep
// [RULE12] software configures pin, clock, channel first
// [RULE13] software waits acquisition time before go
// [RULE14] software polls go or waits interrupt
// [RULE15] software clears done flag after reading
// [RULE16] control layout: channel 6:2, go 1, on 0
// [RULE17] result right-justified, high byte upper zero
// [RULE18] conversion takes eleven bit periods, msb first
// [RULE19] clock select codes choose divider or rc
// [RULE20] channel select drives sample-and-hold mux
// [RULE21] software enables before setting go
// [RULE22] go with converter off does nothing
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
module adc_conversion_sequencer #(
	parameter int data_bits = 10
) (
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	input  wire logic       clk_en_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	input  wire logic       sleep_in,
	input  wire logic       rc_clk_in,
	input  wire logic       compare_in,
	output logic      [4:0] channel_select_out,
	output logic            sample_out,
	output logic            powered_out,
	output logic      [9:0] dac_code_out,
	output logic            irq_out
);
	// the datapath is built for ten result bits only
	if (data_bits != adc_seq_pkg::result_bits) begin : g_bad_width
		$error("data_bits must equal the converter resolution");
	end

	typedef enum logic [1:0] {st_idle, st_acquire, st_convert, st_abort}
		state_t;

	state_t      state_reg;
	logic [4:0]  channel_reg;
	logic        go_reg;
	logic        on_reg;
	logic [2:0]  clksel_reg;
	logic        done_reg;
	logic        irq_en_reg;
	logic [9:0]  result_reg;
	logic [9:0]  sar_reg;
	logic [9:0]  trial_reg;
	logic [3:0]  period_reg;
	logic [7:0]  rdata_reg;
	logic        tick;
	logic        run;
	logic        wr_ctl;
	logic        wr_go1;
	logic        wr_go0;
	logic        complete;
	logic        abort_now;

	assign wr_ctl = wr_in && addr_in == adc_seq_pkg::addr_control;
	assign wr_go1 = wr_ctl && wdata_in[adc_seq_pkg::bit_on]
		&& wdata_in[adc_seq_pkg::bit_go] && on_reg; // RULE22
	assign wr_go0 = wr_ctl && !wdata_in[adc_seq_pkg::bit_go];
	assign run    = on_reg && !sleep_in; // RULE1 RULE11
	assign complete = state_reg == st_convert && tick
		&& period_reg == adc_seq_pkg::conv_periods - 4'h1; // RULE18
	assign abort_now = state_reg == st_convert && wr_go0; // RULE6

	adc_tick_gen u_tick (
		.clk_sys_in    (clk_sys_in),
		.reset_n_in    (reset_n_in),
		.clk_en_in     (clk_en_in),
		.run_in        (run && state_reg != st_idle),
		.clk_select_in (clksel_reg),
		.rc_clk_in     (rc_clk_in),
		.tick_out      (tick) // RULE19
	);

	// writable fields of the control, clock control and status registers
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin // RULE10
			channel_reg <= adc_seq_pkg::control_reset[6:2];
			on_reg      <= adc_seq_pkg::control_reset[0];
			clksel_reg  <= adc_seq_pkg::clock_ctl_reset[6:4];
			irq_en_reg  <= 1'b0;
		end else if (clk_en_in) begin
			if (wr_ctl) begin // RULE16
				channel_reg <= wdata_in[adc_seq_pkg::chan_msb:
					adc_seq_pkg::chan_lsb];
				on_reg <= wdata_in[adc_seq_pkg::bit_on];
			end
			if (wr_in && addr_in == adc_seq_pkg::addr_clock_ctl)
				clksel_reg <= wdata_in[adc_seq_pkg::clksel_msb:
					adc_seq_pkg::clksel_lsb];
			if (wr_in && addr_in == adc_seq_pkg::addr_status)
				irq_en_reg <= wdata_in[adc_seq_pkg::bit_irq_en];
		end
	end

	// go flag: a go write on the same cycle as completion starts again
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			go_reg <= 1'b0;
		else if (clk_en_in) begin
			if (wr_go1)
				go_reg <= 1'b1; // RULE2
			else if (wr_ctl || complete || !run)
				go_reg <= 1'b0; // RULE3
		end
	end

	// sequencer; off or sleep drops any conversion without a result
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg  <= st_idle;
			period_reg <= 4'h0;
		end else if (clk_en_in) begin
			if (!run)
				state_reg <= st_idle; // RULE1 RULE11
			else begin
				case (state_reg)
					st_idle: begin
						state_reg <= st_acquire;
					end
					st_acquire: begin
						if (go_reg) begin
							state_reg  <= st_convert;
							period_reg <= 4'h0;
						end
					end
					st_convert: begin
						if (abort_now) begin
							state_reg  <= st_abort; // RULE6
							period_reg <= 4'h0;
						end else if (complete)
							state_reg <= st_acquire;
						else if (tick)
							period_reg <= period_reg + 4'h1;
					end
					st_abort: begin
						if (tick) begin
							if (period_reg ==
								adc_seq_pkg::abort_periods - 4'h1)
								state_reg <= st_acquire; // RULE8 RULE9
							else
								period_reg <= period_reg + 4'h1;
						end
					end
					default: state_reg <= st_idle;
				endcase
			end
		end
	end

	// successive approximation: period 0 samples, 1..10 resolve b9..b0
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sar_reg   <= 10'h000;
			trial_reg <= 10'h000;
		end else if (clk_en_in) begin
			if (state_reg == st_acquire) begin
				sar_reg   <= 10'h000;
				trial_reg <= 10'h200;
			end else if (state_reg == st_convert && tick
				&& period_reg != 4'h0) begin // RULE18
				if (compare_in)
					sar_reg <= sar_reg | trial_reg;
				trial_reg <= trial_reg >> 1;
			end
		end
	end

	// result loads only on completion, never on abort
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			result_reg <= adc_seq_pkg::result_reset;
		else if (clk_en_in && complete && !abort_now) begin
			if (compare_in)
				result_reg <= sar_reg | trial_reg; // RULE5 RULE7
			else
				result_reg <= sar_reg; // RULE5 RULE7
		end
	end

	// done flag: set wins over a software clear
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			done_reg <= 1'b0;
		else if (clk_en_in) begin
			if (complete && !abort_now)
				done_reg <= 1'b1; // RULE4
			else if (wr_in && addr_in == adc_seq_pkg::addr_status
				&& !wdata_in[adc_seq_pkg::bit_done])
				done_reg <= 1'b0;
		end
	end

	// read port; unmapped addresses read zero
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			rdata_reg <= 8'h00;
		else if (clk_en_in) begin
			if (rd_in) begin
				case (addr_in)
					adc_seq_pkg::addr_control:
						rdata_reg <= {1'b0, channel_reg, go_reg, on_reg};
					adc_seq_pkg::addr_clock_ctl:
						rdata_reg <= {1'b0, clksel_reg, 4'h0};
					adc_seq_pkg::addr_result_high:
						rdata_reg <= {6'h00, result_reg[9:8]}; // RULE17
					adc_seq_pkg::addr_result_low:
						rdata_reg <= result_reg[7:0]; // RULE17
					adc_seq_pkg::addr_status:
						rdata_reg <= {6'h00, irq_en_reg, done_reg};
					default: rdata_reg <= 8'h00;
				endcase
			end else
				rdata_reg <= 8'h00;
		end
	end

	assign rdata_out          = rdata_reg;
	assign channel_select_out = channel_reg; // RULE20
	assign sample_out         = state_reg == st_acquire
		|| (state_reg == st_convert && period_reg == 4'h0);
	assign powered_out        = run;
	assign dac_code_out       = sar_reg | trial_reg;
	assign irq_out            = done_reg & irq_en_reg;

	property p_off_no_convert;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && !on_reg) |=> state_reg == st_idle;
	endproperty
	a_off_no_convert: assert property (p_off_no_convert) // RULE1
		else $error("converter active while off");

	property p_go_starts;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && wr_go1 && state_reg == st_acquire && !sleep_in)
		|=> go_reg ##1 (state_reg == st_convert || !clk_en_in || !run);
	endproperty
	a_go_starts: assert property (p_go_starts) // RULE2
		else $error("go write did not start conversion");

	property p_done_clears_go;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && complete && !wr_go1) |=> !go_reg && done_reg;
	endproperty
	a_done_clears_go: assert property (p_done_clears_go) // RULE3
		else $error("completion left go set or done clear");

	property p_done_sticky;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(done_reg && !(wr_in && addr_in == adc_seq_pkg::addr_status))
		|=> done_reg;
	endproperty
	a_done_sticky: assert property (p_done_sticky) // RULE4
		else $error("done flag dropped without software clear");

	property p_abort_keeps;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && abort_now) |=> $stable(result_reg)
			&& state_reg == st_abort;
	endproperty
	a_abort_keeps: assert property (p_abort_keeps) // RULE7
		else $error("abort changed the result");

	property p_abort_length;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(state_reg == st_abort && tick && period_reg == 4'h0)
		|=> state_reg == st_abort;
	endproperty
	a_abort_length: assert property (p_abort_length) // RULE8
		else $error("abort wait shorter than two periods");

	property p_sleep_idle;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && sleep_in) |=> !complete && state_reg == st_idle;
	endproperty
	a_sleep_idle: assert property (p_sleep_idle) // RULE11
		else $error("converter active during sleep");

	property p_high_zero;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && rd_in && addr_in == adc_seq_pkg::addr_result_high)
		|=> rdata_out[7:2] == 6'h00;
	endproperty
	a_high_zero: assert property (p_high_zero) // RULE17
		else $error("result high byte upper bits not zero");

	property p_off_go_ignored;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(clk_en_in && wr_ctl && !on_reg) |=> !go_reg;
	endproperty
	a_off_go_ignored: assert property (p_off_go_ignored) // RULE22
		else $error("go accepted while converter off");
endmodule

/* sim/analog_front_model.sv */
// analog front end model: sample-and-hold feeding an ideal comparator
`timescale 1ns/1ns
module analog_front_model (
	input  wire logic       clk_sys_in,
	input  wire logic       sample_in,
	input  wire logic       powered_in,
	input  wire logic [9:0] level_in,
	input  wire logic [9:0] dac_code_in,
	output logic            compare_out
);
	logic [9:0] held_reg = 10'h000;
	logic       junk_reg = 1'b0;
	always_ff @(posedge clk_sys_in) begin
		if (sample_in) begin
			held_reg <= level_in;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		junk_reg <= ~junk_reg;
	end
	// unpowered comparator has no meaning, so it must not look stable
	assign compare_out = powered_in ? (held_reg >= dac_code_in) : junk_reg;
endmodule

/* sim/tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module tb_top;
	logic       clk_sys_in = 1'b0;
	logic       rc_clk     = 1'b0;
	logic       reset_n    = 1'b0;
	logic [7:0] addr       = 8'h00;
	logic [7:0] wdata      = 8'h00;
	logic       wr         = 1'b0;
	logic       rd         = 1'b0;
	logic       sleep      = 1'b0;
	logic       clk_en     = 1'b1;
	logic [9:0] level      = 10'h000;
	logic [7:0] rdata;
	logic [4:0] chan;
	logic       sample;
	logic       powered;
	logic       compare;
	logic       irq;
	logic [9:0] dac_code;
	logic [7:0] d;
	logic [9:0] exp_res    = 10'h000;
	logic [9:0] exp_q[$];
	int         mismatches = 0;
	int         tests_run  = 0;
	logic [2:0] sels[6]    = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};

	always #4 clk_sys_in = ~clk_sys_in;
	// rc clock period chosen unrelated to the system clock
	always #37 rc_clk = ~rc_clk;

	adc_conversion_sequencer i_dut (
		.clk_sys_in        (clk_sys_in),
		.reset_n_in        (reset_n),
		.clk_en_in         (clk_en),
		.addr_in           (addr),
		.wdata_in          (wdata),
		.wr_in             (wr),
		.rd_in             (rd),
		.rdata_out         (rdata),
		.sleep_in          (sleep),
		.rc_clk_in         (rc_clk),
		.compare_in        (compare),
		.channel_select_out(chan),
		.sample_out        (sample),
		.powered_out       (powered),
		.dac_code_out      (dac_code),
		.irq_out           (irq)
	);

	analog_front_model i_front (
		.clk_sys_in (clk_sys_in),
		.sample_in  (sample),
		.powered_in (powered),
		.level_in   (level),
		.dac_code_in(dac_code),
		.compare_out(compare)
	);

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a);
		check({2'b00, d}, {2'b00, exp});
	endtask

	task automatic chk_result();
		chk_reg(adc_seq_pkg::addr_result_high, {6'h00, exp_res[9:8]});
		chk_reg(adc_seq_pkg::addr_result_low, exp_res[7:0]);
	endtask

	// poll the go flag until it reads zero, bounded
	task automatic poll_done();
		int n;
		rd_reg(adc_seq_pkg::addr_control);
		for (n = 0; n < 600 && d[1] !== 1'b0; n++) begin
			rd_reg(adc_seq_pkg::addr_control);
		end
	endtask

	task automatic convert(input logic [2:0] sel, input logic [9:0] lvl);
		int per;
		per = (sel[1:0] == 2'b11) ? 0 : 8 << (sel[1] * 2 + sel[2]);
		wr_reg(adc_seq_pkg::addr_clock_ctl, {1'b0, sel, 4'h0});
		level <= lvl;
		exp_q.push_back(lvl);
		repeat (4) @(posedge clk_sys_in);
		wr_reg(adc_seq_pkg::addr_control, 8'h63);
		if (per != 0) begin
			repeat (9 * per) @(posedge clk_sys_in);
			rd_reg(adc_seq_pkg::addr_control);
			check({9'h000, d[1]}, 10'h001);
		end
		poll_done();
		check({2'b00, d}, 10'h061);
		exp_res = exp_q.pop_front();
		check({9'h000, irq}, 10'h001);
		chk_result();
		chk_reg(adc_seq_pkg::addr_status, 8'h03);
		wr_reg(adc_seq_pkg::addr_status, 8'h02);
		chk_reg(adc_seq_pkg::addr_status, 8'h02);
		$display("test conversion sel %h level %h done", sel, lvl);
	endtask

	initial begin
		int i;
		logic [9:0] v;
		void'($urandom(71452));
		repeat (8) @(posedge clk_sys_in);
		reset_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			chk_reg(i[7:0], 8'h00);
		end
		$display("test reset values done");
		wr_reg(adc_seq_pkg::addr_control, 8'h62);
		chk_reg(adc_seq_pkg::addr_control, 8'h60);
		chk_reg(adc_seq_pkg::addr_status, 8'h00);
		wr_reg(adc_seq_pkg::addr_control, 8'he1);
		chk_reg(adc_seq_pkg::addr_control, 8'h61);
		check({5'h00, chan}, 10'h018);
		check({9'h000, powered}, 10'h001);
		wr_reg(adc_seq_pkg::addr_status, 8'h02);
		$display("test control layout done");
		for (i = 0; i < 6; i++) begin
			convert(sels[i], i == 0 ? 10'h3ff : i == 1 ? 10'h000 : 10'($urandom));
		end
		wr_reg(adc_seq_pkg::addr_clock_ctl, 8'h10);
		level <= 10'h155;
		wr_reg(adc_seq_pkg::addr_control, 8'h63);
		repeat (40) @(posedge clk_sys_in);
		wr_reg(adc_seq_pkg::addr_control, 8'h61);
		repeat (8) @(posedge clk_sys_in);
		#1;
		check({9'h000, sample}, 10'h000);
		repeat (30) @(posedge clk_sys_in);
		#1;
		check({9'h000, sample}, 10'h001);
		chk_reg(adc_seq_pkg::addr_control, 8'h61);
		chk_reg(adc_seq_pkg::addr_status, 8'h02);
		chk_result();
		$display("test abort done");
		v = 10'($urandom);
		level <= v;
		exp_q.push_back(v);
		repeat (4) @(posedge clk_sys_in);
		wr_reg(adc_seq_pkg::addr_control, 8'h63);
		repeat (20) @(posedge clk_sys_in);
		clk_en <= 1'b0;
		repeat (200) @(posedge clk_sys_in);
		clk_en <= 1'b1;
		rd_reg(adc_seq_pkg::addr_control);
		check({9'h000, d[1]}, 10'h001);
		poll_done();
		check({2'b00, d}, 10'h061);
		exp_res = exp_q.pop_front();
		chk_result();
		wr_reg(adc_seq_pkg::addr_status, 8'h02);
		$display("test clock enable freeze done");
		wr_reg(adc_seq_pkg::addr_control, 8'h63);
		repeat (20) @(posedge clk_sys_in);
		sleep <= 1'b1;
		repeat (200) @(posedge clk_sys_in);
		#1;
		check({9'h000, powered}, 10'h000);
		chk_reg(adc_seq_pkg::addr_control, 8'h61);
		chk_reg(adc_seq_pkg::addr_status, 8'h02);
		chk_result();
		@(posedge clk_sys_in);
		sleep <= 1'b0;
		$display("test sleep done");
		wr_reg(adc_seq_pkg::addr_control, 8'h63);
		repeat (20) @(posedge clk_sys_in);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		reset_n <= 1'b1;
		exp_res = 10'h000;
		chk_reg(adc_seq_pkg::addr_control, 8'h00);
		chk_result();
		$display("test reset mid conversion done");
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge clk_sys_in);
		mismatches++;
		report_and_stop();
	end
endmodule
